// ### hw/bboe_pkg.sv
// Package: register map, field layout, opcodes and state of the branch unit
package bboe_pkg;
   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_IMM = 8'h04;
   localparam logic [7:0] A_PC = 8'h08;
   localparam logic [7:0] A_SR0 = 8'h0c;
   localparam logic [7:0] A_FLAG = 8'h10;
   localparam logic [7:0] A_LINK = 8'h14;
   localparam logic [7:0] A_SPTR = 8'h18;
   localparam logic [7:0] A_DMEM = 8'h1c;
   localparam logic [7:0] A_IDH = 8'h20;
   localparam logic [7:0] A_CTRL = 8'h24;
   localparam logic [1:0] A_GPR_PAGE = 2'h1;
   // Command word fields
   localparam int CMD_OP = 0;
   localparam int CMD_RSEL = 8;
   localparam int CMD_BPOS = 10;
   localparam int CMD_COND = 13;
   // Status register zero and flag fields
   localparam int SR0_EID = 0;
   localparam int SR0_IE = 1;
   localparam int SR0_BANK = 3;
   localparam int FL_Z = 0;
   localparam int FL_N = 1;
   localparam int FL_TF = 2;
   localparam int FL_PEND = 3;
   localparam int DM_ADDR = 8;
   localparam int DM_WR = 24;
   localparam logic [1:0] LOOP_BANK = 2'h3;
   localparam logic [1:0] BIT_DEST = 2'h3;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] SPTR_STEP = 4'h2;
   localparam logic [11:0] LONG_SKIP = 12'h002;

   typedef enum logic [4:0] {
      OP_PLAIN = 5'h00, OP_LOOP = 5'h01, OP_SCALL = 5'h02,
      OP_LONG_CALL = 5'h03, OP_SLINK = 5'h04, OP_LLINK = 5'h05,
      OP_SRET = 5'h06, OP_INTERRUPT_EXIT = 5'h07, OP_LINK_EXIT = 5'h08,
      OP_BSET = 5'h09, OP_BRST = 5'h0a, OP_BCPL = 5'h0b,
      OP_BTST = 5'h0c, OP_TFCLR = 5'h0d, OP_TFSET = 5'h0e,
      OP_TMASK = 5'h0f, OP_SR0AND = 5'h10, OP_SR0OR = 5'h11,
      OP_BANK = 5'h12
   } bboe_op_t;

   typedef struct packed {
      logic [19:0] pc;
      logic [7:0] sr0;
      logic zf;
      logic nf;
      logic tf;
      logic pend;
      logic [19:0] pend_pc;
      logic [19:0] link;
      logic [3:0] sptr;
      logic [15:0][19:0] hs;
      logic [15:0][7:0] gpr;
      logic [7:0] data_index_high;
      logic [7:0] dm_in;
      logic [7:0] dm_out;
      logic [15:0] dm_addr;
      logic dm_wr;
      logic [19:0] imm;
      logic size_n;
      logic aw_ok;
      logic w_ok;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bboe_state_t;
endpackage

// ### hw/bboe_top.sv
// Branch, link, return and bit-operation execution unit with AXI4-Lite regs
`timescale 1ns/1ps
`default_nettype none

module bboe_top
   import bboe_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address
   input wire logic awvalid,
   input wire logic [ADDR_W-1:0] awaddr,
   output logic awready,
   // Write data
   input wire logic wvalid,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic wready,
   // Write response
   output logic bvalid,
   output logic [1:0] bresp,
   input wire logic bready,
   // Read address
   input wire logic arvalid,
   input wire logic [ADDR_W-1:0] araddr,
   output logic arready,
   // Read data
   output logic rvalid,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic rready
);

   bboe_state_t s_reg;
   bboe_state_t s_next;
   logic go;
   logic exec;
   bboe_op_t op;
   logic [1:0] rsel;
   logic [2:0] bpos;
   logic cok;
   logic [3:0] cidx;
   logic [3:0] gidx;
   logic [3:0] r3idx;
   logic [19:0] pc1;
   logic [19:0] pc2;
   logic [19:0] popv;
   logic [7:0] bmask;
   logic [7:0] bres;
   logic [32:0] rd_w;
   logic [32:0] rd_r;
   logic [31:0] mw;

   ////////////////////////////////////////////////////////////////////////
   // Register read view: bit 32 flags a mapped address
   function automatic logic [32:0] rd_fn(bboe_state_t s, logic [7:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0};
      if (a == A_CMD)
         r[31:0] = 32'h0;
      else if (a == A_IMM)
         r[19:0] = s.imm;
      else if (a == A_PC)
         r[19:0] = s.pc;
      else if (a == A_SR0)
         r[7:0] = s.sr0;
      else if (a == A_FLAG)
         r[3:0] = {s.pend, s.tf, s.nf, s.zf};
      else if (a == A_LINK)
         r[19:0] = s.link;
      else if (a == A_SPTR)
         r[3:0] = s.sptr;
      else if (a == A_DMEM)
         r[24:0] = {s.dm_wr, s.dm_addr, s.dm_out};
      else if (a == A_IDH)
         r[7:0] = s.data_index_high;
      else if (a == A_CTRL)
         r[0] = s.size_n;
      else if (a[7:6] == A_GPR_PAGE)
         r[7:0] = s.gpr[a[5:2]];
      else
         r[32] = 1'b0;
      return r;
   endfunction

   function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
                                         logic [3:0] st);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
            m[8*i +: 8] = d[8*i +: 8];
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      s_next = s_reg;
      go = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
      exec = go && (s_reg.awaddr == A_CMD);
      op = bboe_op_t'(s_reg.wdata[CMD_OP +: 5]);
      rsel = s_reg.wdata[CMD_RSEL +: 2];
      bpos = s_reg.wdata[CMD_BPOS +: 3];
      cok = s_reg.wdata[CMD_COND];
      cidx = {LOOP_BANK, rsel};
      gidx = {s_reg.sr0[SR0_BANK +: 2], rsel};
      r3idx = {s_reg.sr0[SR0_BANK +: 2], BIT_DEST};
      pc1 = s_reg.pc + 20'h1;
      pc2 = s_reg.pc + 20'h2;
      popv = s_reg.hs[4'(s_reg.sptr - SPTR_STEP)];
      bmask = 8'(8'h01 << bpos);
      bres = 8'h00;
      rd_w = rd_fn(s_reg, s_reg.awaddr);
      rd_r = rd_fn(s_reg, araddr);
      mw = merge(rd_w[31:0], s_reg.wdata, s_reg.wstrb);

      // Bus handshakes
      if (awvalid && s_reg.awready)
      begin
         s_next.aw_ok = 1'b1;
         s_next.awaddr = {awaddr[7:2], 2'b00};
         s_next.awready = 1'b0;
      end
      if (wvalid && s_reg.wready)
      begin
         s_next.w_ok = 1'b1;
         s_next.wdata = wdata;
         s_next.wstrb = wstrb;
         s_next.wready = 1'b0;
      end
      if (s_reg.bvalid && bready)
      begin
         s_next.bvalid = 1'b0;
         s_next.awready = 1'b1;
         s_next.wready = 1'b1;
      end
      if (arvalid && s_reg.arready)
      begin
         s_next.arready = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_r[31:0];
         s_next.rresp = rd_r[32] ? RESP_OK : RESP_SLVERR;
      end
      if (s_reg.rvalid && rready)
      begin
         s_next.rvalid = 1'b0;
         s_next.arready = 1'b1;
      end

      // Register writes and command execution
      if (go)
      begin
         s_next.aw_ok = 1'b0;
         s_next.w_ok = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = rd_w[32] ? RESP_OK : RESP_SLVERR;
         if (s_reg.awaddr == A_IMM)
            s_next.imm = mw[19:0];
         else if (s_reg.awaddr == A_PC)
            s_next.pc = mw[19:0];
         else if (s_reg.awaddr == A_SR0)
            s_next.sr0 = mw[7:0];
         else if (s_reg.awaddr == A_LINK)
            s_next.link = mw[19:0];
         else if (s_reg.awaddr == A_DMEM)
            s_next.dm_in = mw[7:0];
         else if (s_reg.awaddr == A_IDH)
            s_next.data_index_high = mw[7:0];
         else if (s_reg.awaddr == A_CTRL)
            s_next.size_n = mw[0];
         else if (s_reg.awaddr[7:6] == A_GPR_PAGE)
            s_next.gpr[s_reg.awaddr[5:2]] = mw[7:0];
      end

      if (exec)
      begin
         s_next.pc = pc1;
         s_next.dm_wr = 1'b0;
         case (op)
            OP_LOOP:
            begin
               s_next.gpr[cidx] = s_reg.gpr[cidx] - 8'h01;
               s_next.pend = 1'b1;
               if (s_reg.gpr[cidx] != 8'h00)
                  s_next.pend_pc = pc1 - {12'h000, s_reg.imm[7:0]};
               else
                  s_next.pend_pc = pc1 + 20'h1;
            end
            OP_SCALL:
            begin
               s_next.hs[s_reg.sptr] = s_reg.size_n ? pc1 :
                                       {4'h0, pc1[15:0]};
               s_next.sptr = s_reg.sptr + SPTR_STEP;
               s_next.pc = {s_reg.pc[19:12], s_reg.imm[11:0]};
            end
            OP_LONG_CALL:
            begin
               if (cok)
               begin
                  s_next.hs[s_reg.sptr] = s_reg.size_n ? pc2 :
                                          {4'h0, pc2[15:0]};
                  s_next.sptr = s_reg.sptr + SPTR_STEP;
                  s_next.pc = s_reg.size_n ? s_reg.imm :
                              {s_reg.pc[19:16], s_reg.imm[15:0]};
               end
               else
                  s_next.pc = {s_reg.pc[19:12], s_reg.pc[11:0] + LONG_SKIP};
            end
            OP_SLINK:
            begin
               s_next.link = s_reg.size_n ? pc1 :
                             {s_reg.link[19:16], pc1[15:0]};
               s_next.pc = {s_reg.pc[19:12], s_reg.imm[11:0]};
            end
            OP_LLINK:
            begin
               s_next.link = s_reg.size_n ? pc2 :
                             {s_reg.link[19:16], pc2[15:0]};
               s_next.pc = s_reg.imm;
            end
            OP_SRET, OP_INTERRUPT_EXIT:
            begin
               s_next.pc = s_reg.size_n ? popv :
                           {s_reg.pc[19:16], popv[15:0]};
               s_next.sptr = s_reg.sptr - SPTR_STEP;
               if (op == OP_INTERRUPT_EXIT)
                  s_next.sr0[SR0_IE] = 1'b1;
            end
            OP_LINK_EXIT:
               s_next.pc = s_reg.size_n ? s_reg.link :
                           {s_reg.pc[19:16], s_reg.link[15:0]};
            OP_BSET, OP_BRST, OP_BCPL, OP_BTST:
            begin
               if (op == OP_BSET)
                  bres = s_reg.dm_in | bmask;
               else if (op == OP_BRST)
                  bres = s_reg.dm_in & ~bmask;
               else if (op == OP_BCPL)
                  bres = s_reg.dm_in ^ bmask;
               else
                  bres = s_reg.dm_in & bmask;
               s_next.dm_addr = {s_reg.sr0[SR0_EID] ? s_reg.data_index_high : 8'h00,
                                 s_reg.imm[7:0]};
               s_next.zf = (bres == 8'h00);
               if (op != OP_BTST)
               begin
                  if (s_reg.tf)
                  begin
                     s_next.dm_out = bres;
                     s_next.dm_wr = 1'b1;
                  end
                  else
                     s_next.gpr[r3idx] = bres;
               end
            end
            OP_TFCLR:
               s_next.tf = 1'b0;
            OP_TFSET:
               s_next.tf = 1'b1;
            OP_TMASK:
            begin
               s_next.zf = ((s_reg.gpr[gidx] & s_reg.imm[7:0]) == 8'h00);
               s_next.nf = s_reg.gpr[gidx][7] & s_reg.imm[7];
            end
            OP_SR0AND:
               s_next.sr0 = s_reg.sr0 & s_reg.imm[7:0];
            OP_SR0OR:
               s_next.sr0 = s_reg.sr0 | s_reg.imm[7:0];
            OP_BANK:
               s_next.sr0[SR0_BANK +: 2] = s_reg.imm[1:0];
            default:
               s_next.pc = pc1;
         endcase
         // Delay slot done: take the loop result
         if (s_reg.pend)
         begin
            s_next.pc = s_reg.pend_pc;
            s_next.pend = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_reg <= '0;
         s_reg.awready <= 1'b1;
         s_reg.wready <= 1'b1;
         s_reg.arready <= 1'b1;
         s_reg.size_n <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   assign awready = s_reg.awready;
   assign wready = s_reg.wready;
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign arready = s_reg.arready;
   assign rvalid = s_reg.rvalid;
   assign rdata = s_reg.rdata;
   assign rresp = s_reg.rresp;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   loop_dec_a: assert property (exec && op == OP_LOOP |=>
      s_reg.gpr[$past(cidx)] == 8'($past(s_reg.gpr[cidx]) - 8'h01))
      else $error("loop counter not decremented");
   loop_back_a: assert property (exec && op == OP_LOOP && !s_reg.pend
      && s_reg.gpr[cidx] != 8'h00 |=> s_reg.pend && s_reg.pend_pc <=
      $past(pc1)) else $error("loop target not backward");
   delay_slot_a: assert property (exec && s_reg.pend |=>
      !s_reg.pend && s_reg.pc == $past(s_reg.pend_pc))
      else $error("delay slot did not resolve branch");
   short_call_a: assert property (exec && op == OP_SCALL && !s_reg.pend |=>
      s_reg.sptr == 4'($past(s_reg.sptr) + 4'h2) &&
      s_reg.pc[19:12] == $past(s_reg.pc[19:12]))
      else $error("short call push or page wrong");
   small_push_a: assert property (exec && op == OP_SCALL
      && !s_reg.size_n |=> s_reg.hs[$past(s_reg.sptr)][19:16] == 4'h0)
      else $error("upper bits pushed for small program");
   long_call_skip_a: assert property (exec && op == OP_LONG_CALL && !cok
      && !s_reg.pend |=> s_reg.sptr == $past(s_reg.sptr) &&
      s_reg.pc[11:0] == 12'($past(s_reg.pc[11:0]) + 12'h002))
      else $error("failed long call wrong");
   ret_pop_a: assert property (exec && (op == OP_SRET || op == OP_INTERRUPT_EXIT)
      |=> s_reg.sptr == 4'($past(s_reg.sptr) - 4'h2))
      else $error("return did not pop");
   interrupt_exit_ie_a: assert property (exec && op == OP_INTERRUPT_EXIT |=>
      s_reg.sr0[SR0_IE]) else $error("interrupt exit left ie clear");
   link_save_a: assert property (exec && op == OP_SLINK |=>
      s_reg.link[15:0] == 16'($past(s_reg.pc[15:0]) + 16'h1))
      else $error("short link saved wrong pc");
   branch_sr_a: assert property (exec && op inside {OP_SCALL, OP_LONG_CALL,
      OP_SLINK, OP_LLINK} |=> $stable(s_reg.sr0) && $stable(s_reg.zf)
      && $stable(s_reg.nf)) else $error("branch changed status");
   bit_test_a: assert property (exec && op == OP_BTST |=>
      $stable(s_reg.gpr) && !s_reg.dm_wr)
      else $error("bit test wrote result");
   bank_sel_a: assert property (exec && op == OP_BANK |=>
      s_reg.sr0[4:3] == $past(s_reg.imm[1:0]))
      else $error("bank select wrong");

   loop_taken_c: cover property (exec && op == OP_LOOP ##[1:20] exec);
   call_ret_c: cover property (exec && op == OP_SCALL ##[1:40]
      exec && op == OP_SRET);
   mem_wr_c: cover property (exec && op == OP_BSET && s_reg.tf);

endmodule

`default_nettype wire

// ### verif/bboe_dmem_model.sv
// Data memory model that supplies bytes to the bit operations
`timescale 1ns/1ps
`default_nettype none
module bboe_dmem_model
(
   // Clock
   input wire logic aclk,
   // Access port
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [7:0] wd,
   output logic [7:0] rd
);
   logic [7:0] mem [0:65535];
   // Each byte starts as its own low address byte
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = i[7:0];
   end
   always @(posedge aclk)
   begin
      if (we)
         mem[addr] <= wd;
   end
   assign rd = mem[addr];
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the branch and bit-operation unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      num_checks++; \
      if ((a) !== (e)) \
      begin \
         err_count++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module tb_top
   import bboe_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, m_we;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, m_wd, m_rd;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] m_addr;
   int err_count, num_checks, cyc;
   bboe_op_t ops [3] = '{OP_BSET, OP_BRST, OP_BCPL};
   logic [2:0] bps [3] = '{3'h1, 3'h0, 3'h7};
   logic [31:0] exps [3] = '{32'h27, 32'h24, 32'ha5};

   bboe_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awaddr(awaddr), .awready(awready), .wvalid(wvalid), .wdata(wdata),
      .wstrb(wstrb), .wready(wready), .bvalid(bvalid), .bresp(bresp),
      .bready(bready), .arvalid(arvalid), .araddr(araddr),
      .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
      .rready(rready));
   bboe_dmem_model u_mem (.aclk(aclk), .we(m_we), .addr(m_addr),
      .wd(m_wd), .rd(m_rd));

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic conclude;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         err_count++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus tasks: entered just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      ta = 1'b0;
      tw = 1'b0;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb)
      begin
         @(negedge aclk);
         if (awvalid && awready)
            ta = 1'b1;
         if (wvalid && wready)
            tw = 1'b1;
         if (bvalid)
         begin
            tb = 1'b1;
            resp = bresp;
         end
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
            bready <= 1'b0;
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic tr, tq;
      tr = 1'b0;
      tq = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr)
      begin
         @(negedge aclk);
         if (arvalid && arready)
            tq = 1'b1;
         if (rvalid)
         begin
            tr = 1'b1;
            d = rdata;
            resp = rresp;
         end
         @(posedge aclk);
         if (tq)
            arvalid <= 1'b0;
         if (tr)
            rready <= 1'b0;
      end
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask

   task automatic chkf(input int b, input logic e);
      rd(A_FLAG, v);
      `CHK(v[b], e)
   endtask

   task automatic ex(input bboe_op_t op, input logic [1:0] r,
      input logic [2:0] b, input logic c, input logic [31:0] imm);
      wr(A_IMM, imm);
      wr(A_CMD, (32'(c) << CMD_COND) | (32'(b) << CMD_BPOS)
         | (32'(r) << CMD_RSEL) | 32'(op));
   endtask

   // Hands the addressed memory byte to the unit
   task automatic feed(input logic [15:0] a);
      m_addr <= a;
      @(posedge aclk);
      wr(A_DMEM, {24'h0, m_rd});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, m_we} = '0;
      {awaddr, araddr, m_wd, wdata, wstrb, m_addr} = '0;
      aresetn = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(A_CTRL, 32'h1);
      chk(A_PC, 32'h0);
      rd(8'h30, v);
      `CHK({resp, v}, {RESP_SLVERR, 32'h0})
      wr(8'h30, 32'h1);
      `CHK(resp, RESP_SLVERR)
      // Short_call, links and returns, large program
      wr(A_SR0, 32'h19);
      wr(A_PC, 32'h18411);
      ex(OP_SCALL, 2'h0, 3'h0, 1'b0, 32'h107);
      chk(A_PC, 32'h18107);
      chk(A_SPTR, 32'h2);
      ex(OP_SRET, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'h18412);
      chk(A_SPTR, 32'h0);
      wr(A_PC, 32'h18411);
      ex(OP_LONG_CALL, 2'h0, 3'h0, 1'b1, 32'h10107);
      chk(A_PC, 32'h10107);
      chk(A_SR0, 32'h19);
      ex(OP_INTERRUPT_EXIT, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'h18413);
      chk(A_SR0, 32'h1b);
      wr(A_PC, 32'h18ffe);
      ex(OP_LONG_CALL, 2'h0, 3'h0, 1'b0, 32'h10107);
      chk(A_PC, 32'h18000);
      chk(A_SPTR, 32'h0);
      wr(A_PC, 32'h18411);
      ex(OP_SLINK, 2'h0, 3'h0, 1'b0, 32'h107);
      chk(A_LINK, 32'h18412);
      chk(A_PC, 32'h18107);
      ex(OP_LLINK, 2'h0, 3'h0, 1'b1, 32'h2abcd);
      chk(A_LINK, 32'h18109);
      chk(A_PC, 32'h2abcd);
      ex(OP_LINK_EXIT, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'h18109);
      chk(A_SR0, 32'h1b);
      // Small program: upper four bits kept out
      wr(A_CTRL, 32'h0);
      wr(A_PC, 32'h38411);
      ex(OP_SCALL, 2'h0, 3'h0, 1'b0, 32'h107);
      wr(A_PC, 32'h5f000);
      ex(OP_SRET, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'h58412);
      wr(A_PC, 32'h38411);
      ex(OP_LONG_CALL, 2'h0, 3'h0, 1'b1, 32'h2abcd);
      chk(A_PC, 32'h3abcd);
      wr(A_LINK, 32'h70000);
      ex(OP_SLINK, 2'h0, 3'h0, 1'b0, 32'h107);
      chk(A_LINK, 32'h7abce);
      wr(A_PC, 32'h5f000);
      ex(OP_LINK_EXIT, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'h5abce);
      wr(A_CTRL, 32'h1);
      // Loop branch with delay slot, counter in bank 3
      wr(A_SR0, 32'h0);
      wr(8'h74, 32'h2);
      wr(A_PC, 32'h100);
      ex(OP_LOOP, 2'h1, 3'h0, 1'b0, 32'h10);
      chk(8'h74, 32'h1);
      chk(8'h44, 32'h0);
      chkf(FL_PEND, 1'b1);
      ex(OP_PLAIN, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'hf1);
      wr(8'h74, 32'h0);
      wr(A_PC, 32'h100);
      ex(OP_LOOP, 2'h1, 3'h0, 1'b0, 32'h10);
      ex(OP_PLAIN, 2'h0, 3'h0, 1'b0, 32'h0);
      chk(A_PC, 32'h102);
      chk(8'h74, 32'hff);
      // Bit operations to R3 of bank 2, index page
      wr(A_SR0, 32'h11);
      wr(A_IDH, 32'h1);
      ex(OP_TFCLR, 2'h0, 3'h0, 1'b0, 32'h0);
      chkf(FL_TF, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         feed(16'h0125);
         ex(ops[i], 2'h0, bps[i], 1'b0, 32'h25);
         chk(8'h6c, exps[i]);
         chkf(FL_Z, 1'b0);
      end
      chk(A_DMEM, 32'h012500);
      ex(OP_BTST, 2'h0, 3'h1, 1'b0, 32'h25);
      chkf(FL_Z, 1'b1);
      ex(OP_BTST, 2'h0, 3'h2, 1'b0, 32'h25);
      chkf(FL_Z, 1'b0);
      chk(8'h6c, 32'ha5);
      // Result back to memory, page zero
      ex(OP_TFSET, 2'h0, 3'h0, 1'b0, 32'h0);
      chkf(FL_TF, 1'b1);
      wr(A_SR0, 32'h10);
      feed(16'h0001);
      ex(OP_BRST, 2'h0, 3'h0, 1'b0, 32'h1);
      chkf(FL_Z, 1'b1);
      chk(8'h6c, 32'ha5);
      rd(A_DMEM, v);
      `CHK(v[24:0], {1'b1, 16'h0001, 8'h00})
      m_we <= v[24];
      m_wd <= v[7:0];
      m_addr <= v[23:8];
      @(posedge aclk);
      m_we <= 1'b0;
      ex(OP_TFCLR, 2'h0, 3'h0, 1'b0, 32'h0);
      chkf(FL_TF, 1'b0);
      // Test under mask on bank 2 register 1
      wr(8'h64, 32'h85);
      ex(OP_TMASK, 2'h1, 3'h0, 1'b0, 32'h80);
      rd(A_FLAG, v);
      `CHK(v[1:0], 2'b10)
      ex(OP_TMASK, 2'h1, 3'h0, 1'b0, 32'h7a);
      rd(A_FLAG, v);
      `CHK(v[1:0], 2'b01)
      chk(8'h64, 32'h85);
      // Status register zero logic and bank select
      ex(OP_SR0OR, 2'h0, 3'h0, 1'b0, 32'h07);
      chk(A_SR0, 32'h17);
      ex(OP_SR0AND, 2'h0, 3'h0, 1'b0, 32'hf5);
      chk(A_SR0, 32'h15);
      ex(OP_BANK, 2'h0, 3'h0, 1'b0, 32'h5);
      chk(A_SR0, 32'h0d);
      conclude();
   end
endmodule
`default_nettype wire
